// ---- cwr_defs.vh ----
`ifndef CWR_DEFS_VH
`define CWR_DEFS_VH

// ----------------------------------------------------------------
// Register map (index times four gives the byte address)
// ----------------------------------------------------------------
`define CWR_ADDR_W 12
`define CWR_CTRL_INDEX 8'h2a
`define CWR_STAT_INDEX 8'h2b
`define CWR_CTRL_ADDR ({2'h0, `CWR_CTRL_INDEX, 2'h0})
`define CWR_STAT_ADDR ({2'h0, `CWR_STAT_INDEX, 2'h0})

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CWR_ACT_BIT 7
`define CWR_TOP_BIT 6
`define CWR_CNT_W 7
`define CWR_CTRL_RESET 8'h7f
`define CWR_COUNT_RESET 7'h7f
`define CWR_EXPIRE_COUNT 7'h40

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define CWR_ST_ACTIVE 0
`define CWR_ST_HWOPT 1
`define CWR_ST_HALTOPT 2
`define CWR_ST_TB_LO 3
`define CWR_ST_TB_HI 4

// ----------------------------------------------------------------
// Prescaler and timebase phase constants
// ----------------------------------------------------------------
`define CWR_PRESCALE_CYCLES 16384
`define CWR_PRESCALE_W 14
`define CWR_PHASE_BASE 128
`define CWR_PHASE_UNIT 64
`define CWR_TB0_LSB 59
`define CWR_TB1_LSB 53
`define CWR_TB2_LSB 35
`define CWR_TB3_LSB 54
`define CWR_TB_2MS 2'h0
`define CWR_TB_4MS 2'h1
`define CWR_TB_10MS 2'h2
`define CWR_TB_25MS 2'h3

`endif

// ---- cwr_prescaler.v ----
`default_nettype none
`include "cwr_defs.vh"

module cwr_prescaler #(
    parameter PERIOD = `CWR_PRESCALE_CYCLES,
    parameter WIDTH = `CWR_PRESCALE_W
) (
    input wire ref_clk,
    input wire rst_b,
    input wire phaseLoad,
    input wire [WIDTH-1:0] phaseValue,
    output reg tick
);

reg [WIDTH-1:0] count_reg;
reg [WIDTH-1:0] count_next;
wire atEnd;

assign atEnd = (count_reg == PERIOD[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1});

// ----------------------------------------------------------------
// Free-running divider; only a timebase change moves its phase
// ----------------------------------------------------------------
always @* begin
    if (phaseLoad) begin
        count_next = phaseValue;
    end else if (atEnd) begin
        count_next = {WIDTH{1'b0}};
    end else begin
        count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        count_reg <= {WIDTH{1'b0}};
        tick <= 1'b0;
    end else begin
        count_reg <= count_next;
        tick <= atEnd & ~phaseLoad;
    end
end

endmodule // cwr_prescaler

`default_nettype wire

// ---- cwr_strap_capture.v ----
`default_nettype none

module cwr_strap_capture #(
    parameter WIDTH = 2
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] strapIn,
    output reg [WIDTH-1:0] strapValue
);

reg taken_reg;

// ----------------------------------------------------------------
// Options are sampled once, on the first edge after reset release
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        taken_reg <= 1'b0;
        strapValue <= {WIDTH{1'b0}};
    end else if (!taken_reg) begin
        taken_reg <= 1'b1;
        strapValue <= strapIn;
    end
end

endmodule // cwr_strap_capture

`default_nettype wire

// ---- cwr_watchdog.v ----
// Notes on behaviour
// - The count drops by one on every prescaler tick, one tick per 16384 clock cycles.
// - The six low count bits set the timeout in 64 equal steps.
// - With the watchdog active, a decrement from 40h to 3Fh requests a chip reset.
// - The count decrements whether or not the watchdog is active.
// - A control write never touches the prescaler, so the first decrement depends on its phase.
// - Without the hardware option the watchdog starts inactive after reset and, once activated, stays active until reset.
// - Writing activation set with the top count bit clear requests an immediate reset.
// - With the watchdog active and the halt option on, a halt request gives a reset, not halt.
// - An option input makes the watchdog a hardware watchdog, active from reset.
// - The timebase selection sets the prescaler phase, shaping minimum and maximum timeout.
// - Activation is bit 7, set by software, cleared only by reset; the register resets to 7Fh.
// - With the hardware option on, the watchdog is always active and the activation bit is moot.
//
// Our own choices: the register addresses and register access over APB.
`default_nettype none
`include "cwr_defs.vh"

module cwr_watchdog #(
    parameter PRESCALE_CYCLES = `CWR_PRESCALE_CYCLES,
    parameter ADDR_W = `CWR_ADDR_W
) (
    input wire ref_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire hwWatchdogOption,
    input wire haltResetOption,
    input wire [1:0] timebaseSelect,
    input wire haltExecute,
    output reg haltEnter,
    output reg watchdogResetRequest
);

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire selCtrl;
wire selStat;
wire mapped;
wire setupPhase;
wire accessPhase;
wire wrCtrl;

assign selCtrl = (paddr == `CWR_CTRL_ADDR);
assign selStat = (paddr == `CWR_STAT_ADDR);
assign mapped = selCtrl | selStat;
assign setupPhase = psel & ~penable;
assign accessPhase = psel & penable;
// Zero wait states: every access completes in its first access cycle
assign pready = 1'b1;
assign pslverr = accessPhase & ~mapped;
assign wrCtrl = accessPhase & pwrite & selCtrl;

// ----------------------------------------------------------------
// Option straps
// ----------------------------------------------------------------
wire [1:0] strapValue;
wire hwOption;
wire haltOption;

cwr_strap_capture #(
    .WIDTH(2)
) u_straps (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .strapIn({haltResetOption, hwWatchdogOption}),
    .strapValue(strapValue)
);

assign hwOption = strapValue[0];
assign haltOption = strapValue[1];

// ----------------------------------------------------------------
// Timebase phase link
// ----------------------------------------------------------------
reg [1:0] tbPrev_reg;
reg [31:0] phaseOffset;
reg [`CWR_PRESCALE_W-1:0] phaseValue;
wire phaseLoad;
wire tick;

assign phaseLoad = (timebaseSelect != tbPrev_reg);

always @* begin
    case (timebaseSelect)
        `CWR_TB_2MS: phaseOffset = (`CWR_TB0_LSB + `CWR_PHASE_BASE) * `CWR_PHASE_UNIT;
        `CWR_TB_4MS: phaseOffset = (`CWR_TB1_LSB + `CWR_PHASE_BASE) * `CWR_PHASE_UNIT;
        `CWR_TB_10MS: phaseOffset = (`CWR_TB2_LSB + `CWR_PHASE_BASE) * `CWR_PHASE_UNIT;
        default: phaseOffset = (`CWR_TB3_LSB + `CWR_PHASE_BASE) * `CWR_PHASE_UNIT;
    endcase
    // A shortened simulation period can be smaller than the offset
    if (phaseOffset >= PRESCALE_CYCLES) begin
        phaseValue = {`CWR_PRESCALE_W{1'b0}};
    end else begin
        phaseValue = PRESCALE_CYCLES[`CWR_PRESCALE_W-1:0] - phaseOffset[`CWR_PRESCALE_W-1:0];
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        tbPrev_reg <= `CWR_TB_2MS;
    end else begin
        tbPrev_reg <= timebaseSelect;
    end
end

// Control writes do not reach the divider, hence the timeout spread
cwr_prescaler #(
    .PERIOD(PRESCALE_CYCLES),
    .WIDTH(`CWR_PRESCALE_W)
) u_prescaler (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .phaseLoad(phaseLoad),
    .phaseValue(phaseValue),
    .tick(tick)
);

// ----------------------------------------------------------------
// Counter and activation
// ----------------------------------------------------------------
reg [`CWR_CNT_W-1:0] count_reg;
reg [`CWR_CNT_W-1:0] count_next;
reg activate_reg;
wire activate_next;
wire activeNow;
wire expire;
wire softReset;
wire haltReset;

always @* begin
    if (wrCtrl) begin
        count_next = pwdata[`CWR_CNT_W-1:0];
    end else if (tick) begin
        count_next = count_reg - {{(`CWR_CNT_W-1){1'b0}}, 1'b1};
    end else begin
        count_next = count_reg;
    end
end

// Activation is sticky; nothing but reset clears it
assign activate_next = activate_reg | (wrCtrl & pwdata[`CWR_ACT_BIT]);
assign activeNow = activate_reg | hwOption;

assign expire = tick & ~wrCtrl & activeNow & (count_reg == `CWR_EXPIRE_COUNT);
// A write counts as active if it sets activation itself
assign softReset = wrCtrl & ~pwdata[`CWR_TOP_BIT]
                   & (activeNow | pwdata[`CWR_ACT_BIT]);
assign haltReset = haltExecute & activeNow & haltOption;

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        count_reg <= `CWR_COUNT_RESET;
        activate_reg <= 1'b0;
        watchdogResetRequest <= 1'b0;
        haltEnter <= 1'b0;
    end else begin
        count_reg <= count_next;
        activate_reg <= activate_next;
        watchdogResetRequest <= expire | softReset | haltReset;
        haltEnter <= haltExecute & ~haltReset;
    end
end

// ----------------------------------------------------------------
// Read data, captured in the setup cycle
// ----------------------------------------------------------------
reg [31:0] readValue;

always @* begin
    readValue = 32'h0000_0000;
    if (selCtrl) begin
        readValue[`CWR_ACT_BIT] = activate_reg;
        readValue[`CWR_CNT_W-1:0] = count_reg;
    end else if (selStat) begin
        readValue[`CWR_ST_ACTIVE] = activeNow;
        readValue[`CWR_ST_HWOPT] = hwOption;
        readValue[`CWR_ST_HALTOPT] = haltOption;
        readValue[`CWR_ST_TB_HI:`CWR_ST_TB_LO] = timebaseSelect;
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        prdata <= 32'h0000_0000;
    end else if (setupPhase & ~pwrite) begin
        prdata <= readValue;
    end
end

endmodule // cwr_watchdog

`default_nettype wire

// ---- cwr_watchdog_asserts.sv ----
`default_nettype none
`include "cwr_defs.vh"
module cwr_watchdog_asserts #(
    parameter ADDR_W = `CWR_ADDR_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hwWatchdogOption,
    input wire logic haltResetOption,
    input wire logic haltExecute,
    input wire logic haltEnter,
    input wire logic watchdogResetRequest
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr == `CWR_CTRL_ADDR || paddr == `CWR_STAT_ADDR;
    sequence ctrlWrite;
        acc && pwrite && paddr == `CWR_CTRL_ADDR;
    endsequence
    // Straps land one edge after release, so a halt on that edge is left out
    sequence haltReq;
        haltExecute && $past(rst_b);
    endsequence
    chk_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready low in access");
    chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped address");
    chk_soft_reset: assert property (
        ctrlWrite ##0 (pwdata[7] && !pwdata[6]) |=> watchdogResetRequest)
        else $error("no reset after soft reset write");
    chk_req_single: assert property (watchdogResetRequest |=> !watchdogResetRequest)
        else $error("reset request longer than one cycle");
    chk_halt_enters: assert property (
        haltReq ##0 !haltResetOption |=> haltEnter || watchdogResetRequest)
        else $error("halt not entered");
    chk_halt_resets: assert property (
        haltReq ##0 (haltResetOption && hwWatchdogOption) |=> watchdogResetRequest && !haltEnter)
        else $error("halt did not reset");
    chk_halt_cause: assert property (haltEnter |-> $past(haltExecute))
        else $error("halt entered without request");
endmodule // cwr_watchdog_asserts
`default_nettype wire

// ---- cwr_reset_seq.sv ----
`default_nettype none
module cwr_reset_seq (
    input wire logic ref_clk,
    input wire logic porB,
    input wire logic resetRequest,
    output logic rstB
);
    timeunit 1ns / 1ns;
    logic [2:0] hold_reg;
    // Four low cycles, long enough for the block's asynchronous clear to land
    always_ff @(posedge ref_clk or negedge porB) begin
        if (!porB) begin
            hold_reg <= 3'h0;
        end else if (resetRequest) begin
            hold_reg <= 3'h4;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end
    assign rstB = porB && hold_reg == 3'h0;
endmodule // cwr_reset_seq
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
`include "cwr_defs.vh"
module tb;
    timeunit 1ns / 1ns;
    logic ref_clk = 1'b0;
    logic porB = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hwOpt = 1'b0, haltOpt = 1'b0, haltExecute = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] tbSel = 2'h2;
    logic rst_b, pready, pslverr, haltEnter, watchdogResetRequest, rdErr;
    logic [31:0] prdata, rdData;
    int fail_count = 0, num_checks = 0, reqCount = 0;
    cwr_watchdog #(.PRESCALE_CYCLES(64)) i_cwr_watchdog (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .hwWatchdogOption(hwOpt), .haltResetOption(haltOpt), .timebaseSelect(tbSel),
        .haltExecute(haltExecute), .haltEnter(haltEnter),
        .watchdogResetRequest(watchdogResetRequest));
    cwr_reset_seq i_cwr_reset_seq (.ref_clk(ref_clk), .porB(porB),
        .resetRequest(watchdogResetRequest), .rstB(rst_b));
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (watchdogResetRequest === 1'b1) reqCount <= reqCount + 1;
    initial begin
        #(50 * 20000);
        fail_count++;
        finish_test();
    end
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the watchdog process ends a wait that never sees pready
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdData);
    endtask
    task automatic halt(input logic expEnter);
        @(posedge ref_clk);
        haltExecute <= 1'b1;
        @(posedge ref_clk);
        haltExecute <= 1'b0;
        @(posedge ref_clk);
        chk("haltEnter", 32'(expEnter), 32'(haltEnter));
        chk("halt reset", 32'(!expEnter), 32'(watchdogResetRequest));
    endtask
    // A timebase change restarts the divider: tick after 65 edges, decrement one later
    task automatic phase_link(input logic [1:0] code);
        @(posedge ref_clk);
        tbSel <= code;
        apb(1'b1, `CWR_CTRL_ADDR, 32'h50);
        repeat (61) @(posedge ref_clk);
        rd("before tick", `CWR_CTRL_ADDR, 32'h50);
        rd("after tick", `CWR_CTRL_ADDR, 32'h4f);
        rd("tb status", `CWR_STAT_ADDR, {27'h0, code, 3'h0});
    endtask
    // Four ticks from 43h; prescaler phase at the write is unknown
    task automatic expire(input logic [31:0] d);
        int n = 0;
        apb(1'b1, `CWR_CTRL_ADDR, d);
        while (watchdogResetRequest !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk("expiry cycles", 32'h1, 32'(n >= 194 && n <= 257));
        repeat (8) @(posedge ref_clk);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        porB <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd("ctrl", `CWR_CTRL_ADDR, 32'h7f);
        rd("status", `CWR_STAT_ADDR, 32'h10);
        rd("unmapped", 12'h000, 32'h0);
        chk("pslverr", 32'h1, 32'(rdErr));
        apb(1'b1, `CWR_CTRL_ADDR, 32'h45);
        repeat (448) @(posedge ref_clk);
        apb(1'b0, `CWR_CTRL_ADDR, 32'h0);
        chk("free count", 32'h1, 32'(rdData == 32'h3e || rdData == 32'h3d));
        chk("idle requests", 32'h0, 32'(reqCount));
        phase_link(2'h0);
        phase_link(2'h1);
        phase_link(2'h3);
        tbSel <= 2'h2;
        halt(1'b1);
        apb(1'b1, `CWR_CTRL_ADDR, 32'hff);
        apb(1'b1, `CWR_CTRL_ADDR, 32'h7f);
        rd("sticky", `CWR_STAT_ADDR, 32'h11);
        hwOpt <= 1'b1;
        haltOpt <= 1'b1;
        apb(1'b1, `CWR_CTRL_ADDR, 32'h80);
        @(posedge ref_clk);
        chk("soft reset", 32'h1, 32'(watchdogResetRequest));
        repeat (8) @(posedge ref_clk);
        rd("ctrl again", `CWR_CTRL_ADDR, 32'h7f);
        rd("hw status", `CWR_STAT_ADDR, 32'h17);
        expire(32'h43);
        halt(1'b0);
        repeat (8) @(posedge ref_clk);
        finish_test();
    end
endmodule // tb
bind cwr_watchdog cwr_watchdog_asserts #(.ADDR_W(ADDR_W)) i_cwr_watchdog_asserts (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .hwWatchdogOption(hwWatchdogOption), .haltResetOption(haltResetOption),
    .haltExecute(haltExecute), .haltEnter(haltEnter),
    .watchdogResetRequest(watchdogResetRequest));
`default_nettype wire
